// [aux_cal_defs.vh]
// Register offsets, field positions, reset values and codes for the auxiliary calibration register slice
`ifndef AUX_CAL_DEFS_VH
`define AUX_CAL_DEFS_VH
`define ADDR_W            8
`define DATA_W            16
`define OFF_SPARE         8'h8D
`define OFF_OCAL          8'h8E
`define OFF_GCAL          8'h8F
`define OFF_STEP0         8'h90
`define RST_SPARE         8'h00
`define RST_WORD          16'h0000
`define RST_GAIN          2'h0
`define RST_POS           4'h0
`define SPARE_HI          7
`define STEP_EN_BIT       15
`define STEP_GAIN_HI      14
`define STEP_GAIN_LO      13
`define STEP_NEG_BIT      4
`define STEP_POS_HI       3
`define STEP_POS_LO       0
`define GAIN_X1           2'h0
`define GAIN_X2           2'h1
`define POS_INTERNAL_BIT  3
`define NEG_GROUND        1'b0
`define NEG_EIGHTH        1'b1
`define SAT_MAX           16'h7FFF
`define SAT_MIN           16'h8000
`define GAIN_FRAC_BITS    16
`endif

// [aux_corrector.v]
// Offset and gain correction of one auxiliary conversion result, with saturation
`include "aux_cal_defs.vh"
module aux_corrector (
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // Correction words
  input  wire [15:0] aux_offset_value,
  input  wire [15:0] aux_gain_value,
  input  wire        half_step,
  // Sample in
  input  wire        raw_valid,
  input  wire [15:0] raw_data,
  // Sample out
  output reg         cor_valid_q,
  output reg  [15:0] cor_data_q
);
  wire signed [17:0] off_scaled;
  wire signed [18:0] diff;
  wire signed [17:0] mult;
  wire signed [36:0] prod;
  wire signed [20:0] shifted;
  reg         [15:0] sat;

  // At gain 2 or 4 one offset step is half a gain-1 step: keep a fraction bit
  assign off_scaled = half_step ? {{2{aux_offset_value[15]}}, aux_offset_value}
                                : {aux_offset_value[15], aux_offset_value, 1'b0};
  assign diff    = {{2{raw_data[15]}}, raw_data, 1'b0} - {off_scaled[17], off_scaled};
  // Multiplier 1 + value/65536, from 0.5 to just below 1.5
  assign mult    = {2'b01, 16'h0000} + {{2{aux_gain_value[15]}}, aux_gain_value};
  assign prod    = diff * mult;
  assign shifted = prod[36:`GAIN_FRAC_BITS];

  // Result carries one fraction bit in bit 0, dropped after saturation
  always @* begin
    if (shifted > $signed({4'h0, `SAT_MAX, 1'b1}))
      sat = `SAT_MAX;
    else if (shifted < $signed({4'hF, `SAT_MIN, 1'b0}))
      sat = `SAT_MIN;
    else
      sat = shifted[16:1];
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      cor_valid_q <= 1'b0;
      cor_data_q  <= `RST_WORD;
    end else begin
      cor_valid_q <= raw_valid;
      if (raw_valid)
        cor_data_q <= sat;
    end
  end
endmodule

// [aux_adc_cal_seq_step_regs.v]
// Register slice for auxiliary converter calibration words and sequencer step zero
`include "aux_cal_defs.vh"
module aux_adc_cal_seq_step_regs (
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata_q,
  // Sequencer step zero configuration
  output wire        step_zero_enable,
  output wire [2:0]  step_zero_gain_factor,
  output wire [3:0]  step_zero_pos_input,
  output wire        step_zero_neg_input,
  output wire        step_zero_neg_auto,
  output wire        step_zero_pos_internal,
  // Auxiliary conversion results
  input  wire        raw_valid,
  input  wire [15:0] raw_data,
  output wire        cor_valid,
  output wire [15:0] cor_data
);
  reg  [7:0]  spare_q;
  reg  [15:0] aux_offset_value_q;
  reg  [15:0] aux_gain_value_q;
  reg         step_en_q;
  reg  [1:0]  step_gain_q;
  reg         step_neg_q;
  reg  [3:0]  step_pos_q;
  reg  [15:0] rdata_d;
  wire        internal_src;
  wire        half_step;

  always @(posedge clk) begin
    if (sys_rst) begin
      spare_q            <= `RST_SPARE;
      aux_offset_value_q <= `RST_WORD;
      aux_gain_value_q   <= `RST_WORD;
      step_en_q          <= 1'b0;
      step_gain_q        <= `RST_GAIN;
      step_neg_q         <= `NEG_GROUND;
      step_pos_q         <= `RST_POS;
    end else if (reg_wr) begin
      if (reg_addr == `OFF_SPARE) begin
        spare_q <= reg_wdata[`SPARE_HI:0];
      end else if (reg_addr == `OFF_OCAL) begin
        aux_offset_value_q <= reg_wdata;
      end else if (reg_addr == `OFF_GCAL) begin
        aux_gain_value_q <= reg_wdata;
      end else if (reg_addr == `OFF_STEP0) begin
        step_en_q   <= reg_wdata[`STEP_EN_BIT];
        step_gain_q <= reg_wdata[`STEP_GAIN_HI:`STEP_GAIN_LO];
        step_neg_q  <= reg_wdata[`STEP_NEG_BIT];
        step_pos_q  <= reg_wdata[`STEP_POS_HI:`STEP_POS_LO];
      end
    end
  end

  // Reserved bits and unmapped addresses read as zero
  always @* begin
    rdata_d = `RST_WORD;
    if (reg_addr == `OFF_SPARE) begin
      rdata_d = {8'h00, spare_q};
    end else if (reg_addr == `OFF_OCAL) begin
      rdata_d = aux_offset_value_q;
    end else if (reg_addr == `OFF_GCAL) begin
      rdata_d = aux_gain_value_q;
    end else if (reg_addr == `OFF_STEP0) begin
      rdata_d = {step_en_q, step_gain_q, 8'h00, step_neg_q, step_pos_q};
    end
  end

  // Read data hold only in the cycle after the strobe
  always @(posedge clk) begin
    if (sys_rst)
      reg_rdata_q <= `RST_WORD;
    else if (reg_rd)
      reg_rdata_q <= rdata_d;
    else
      reg_rdata_q <= `RST_WORD;
  end

  // Step decode; the spare byte feeds only the read-back mux and drives no other logic
  assign step_zero_enable       = step_en_q;
  assign step_zero_gain_factor  = (step_gain_q == `GAIN_X1) ? 3'h1 :
                                  (step_gain_q == `GAIN_X2) ? 3'h2 : 3'h4;
  assign internal_src           = step_pos_q[`POS_INTERNAL_BIT];
  assign step_zero_pos_internal = internal_src;
  assign step_zero_pos_input    = step_pos_q;
  assign step_zero_neg_auto     = internal_src;
  assign step_zero_neg_input    = internal_src ? `NEG_GROUND : step_neg_q;
  assign half_step              = (step_gain_q != `GAIN_X1);

  aux_corrector u_cor (
    .clk              (clk),
    .sys_rst          (sys_rst),
    .aux_offset_value (aux_offset_value_q),
    .aux_gain_value   (aux_gain_value_q),
    .half_step        (half_step),
    .raw_valid        (raw_valid),
    .raw_data         (raw_data),
    .cor_valid_q      (cor_valid),
    .cor_data_q       (cor_data)
  );
endmodule

// [aux_cal_checker_properties.sv]
// Timing and field assertions for the calibration register slice
module aux_cal_checker (
  // Clock, reset and register port
  input wire logic        clk, sys_rst, reg_wr, reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata, reg_rdata_q,
  // Step zero and correction outputs
  input wire logic        step_zero_enable, step_zero_neg_input, step_zero_neg_auto, step_zero_pos_internal,
  input wire logic [2:0]  step_zero_gain_factor,
  input wire logic [3:0]  step_zero_pos_input,
  input wire logic        raw_valid, cor_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Write data one cycle back, for checks that land after the write edge
  logic [15:0] w_q;
  always_ff @(posedge clk) w_q <= reg_wdata;
  sequence ocal_wr_rd;
    reg_wr && reg_addr == 8'h8E ##1 reg_rd && reg_addr == 8'h8E;
  endsequence
  chk_rd_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata_q == 16'h0000)
    else $error("read data not zero outside read cycle");
  chk_spare_upper: assert property ($past(reg_rd) && $past(reg_addr) == 8'h8D |-> reg_rdata_q[15:8] == 8'h00)
    else $error("spare upper byte not zero");
  chk_step_reserved: assert property ($past(reg_rd) && $past(reg_addr) == 8'h90 |-> (reg_rdata_q & 16'h1FE0) == 0)
    else $error("step word reserved bits not zero");
  chk_unmapped_zero: assert property ($past(reg_rd) && ($past(reg_addr) < 8'h8D || $past(reg_addr) > 8'h90)
    |-> reg_rdata_q == 16'h0000) else $error("unmapped read not zero");
  chk_offset_back: assert property (ocal_wr_rd |=> reg_rdata_q == $past(reg_wdata, 2))
    else $error("offset word readback wrong");
  chk_cor_latency: assert property (raw_valid |=> cor_valid) else $error("result valid late");
  chk_cor_spurious: assert property (!raw_valid |=> !cor_valid) else $error("result valid without sample");
  chk_neg_auto: assert property (step_zero_neg_auto == step_zero_pos_input[3] && step_zero_pos_internal ==
    step_zero_pos_input[3] && !(step_zero_pos_input[3] && step_zero_neg_input)) else $error("negative input select wrong");
  chk_gain_decode: assert property (reg_wr && reg_addr == 8'h90 |=> step_zero_enable == w_q[15] &&
    step_zero_gain_factor == (w_q[14] ? 3'h4 : w_q[13] ? 3'h2 : 3'h1)) else $error("step gain decode wrong");
endmodule
bind aux_adc_cal_seq_step_regs aux_cal_checker aux_cal_checker_i (.*);

// [aux_adc_cal_seq_step_regs_test.sv]
// Self-checking bench for the calibration register slice
module aux_adc_cal_seq_step_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, raw_valid = 0, cor_valid;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, raw_data = 16'h0000, reg_rdata_q, cor_data;
  logic        step_zero_enable, step_zero_neg_input, step_zero_neg_auto, step_zero_pos_internal;
  logic [2:0]  step_zero_gain_factor;
  logic [3:0]  step_zero_pos_input;
  int          error_cnt = 0, check_count = 0;
  always #2.5 clk = ~clk;
  aux_adc_cal_seq_step_regs aux_adc_cal_seq_step_regs_i (.*);
  task chk(input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Strobe is left high so writes can follow each other; the next task lowers it
  task wr(input logic [7:0] a, input logic [15:0] d);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk);
  endtask
  // Read data stands only in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [15:0] e);
    {reg_wr, reg_rd, reg_addr} <= {1'b0, 1'b1, a};
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata_q, e);
    @(posedge clk);
  endtask
  task samp(input logic [15:0] x, e);
    {reg_wr, raw_valid, raw_data} <= {1'b0, 1'b1, x};
    @(posedge clk);
    raw_valid <= 1'b0;
    #1 chk({15'h0000, cor_valid}, 16'h0001);
    chk(cor_data, e);
    @(posedge clk);
  endtask
  task step(input logic [15:0] w, input logic [2:0] g, input logic [3:0] f);
    wr(8'h90, w);
    reg_wr <= 1'b0;
    #1 chk({13'h0000, step_zero_gain_factor}, {13'h0000, g});
    chk({12'h000, step_zero_enable, step_zero_neg_input, step_zero_neg_auto, step_zero_pos_internal}, {12'h000, f});
    chk({12'h000, step_zero_pos_input}, {12'h000, w[3:0]});
    @(posedge clk);
  endtask
  task t_regs;
    for (int a = 8'h8D; a <= 8'h90; a++) rd(8'(a), 16'h0000);
    wr(8'h8D, 16'hFFFF);
    rd(8'h8D, 16'h00FF);
    wr(8'h8E, 16'h8000);
    rd(8'h8E, 16'h8000);
    wr(8'h8F, 16'h7FFF);
    rd(8'h8F, 16'h7FFF);
    wr(8'h90, 16'hFFFF);
    rd(8'h90, 16'hE01F);
    wr(8'h91, 16'h1234);
    rd(8'h91, 16'h0000);
    $display("register access done");
  endtask
  task t_step;
    step(16'h0007, 3'h1, 4'b0000);
    step(16'hA017, 3'h2, 4'b1100);
    step(16'h4018, 3'h4, 4'b0011);
    step(16'hE00F, 3'h4, 4'b1011);
    step(16'h0010, 3'h1, 4'b0100);
    $display("step decode done");
  endtask
  task t_cor;
    wr(8'h8E, 16'h0000);
    wr(8'h8F, 16'h0000);
    wr(8'h90, 16'h0000);
    samp(16'h8123, 16'h8123);
    wr(8'h8E, 16'h000A);
    samp(16'h0100, 16'h00F6);
    wr(8'h90, 16'h2000);
    samp(16'h0100, 16'h00FB);
    wr(8'h90, 16'h0000);
    wr(8'h8E, 16'h0000);
    wr(8'h8F, 16'h8000);
    samp(16'h03E8, 16'h01F4);
    wr(8'h8F, 16'h0000);
    wr(8'h8E, 16'h8000);
    samp(16'h7FFF, 16'h7FFF);
    wr(8'h8E, 16'h7FFF);
    samp(16'h8000, 16'h8000);
    $display("correction done");
  endtask
  task finish_test;
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs;
    t_step;
    t_cor;
    finish_test;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #20000;
    error_cnt++;
    finish_test;
  end
endmodule
